/* pkg/secl_pkg.sv */
package secl_pkg;
	// ----------------------------------------------------------------
	// widths and frame layout
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int IDX_W = 8;
	localparam int FRAME_W = 32;
	localparam int LEN_W = 6;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_EXT = 2'h0;
	localparam logic [1:0] EXT_WEN = 2'h3;
	localparam logic [1:0] EXT_WDS = 2'h0;
	localparam logic START_BIT = 1'h1;
	localparam logic [LEN_W-1:0] HEAD_BITS = 6'h03;
	localparam logic [LEN_W-1:0] DATA_BITS = 6'h10;
	localparam logic [LEN_W-1:0] RX_BITS = 6'h10;
	localparam logic SDI_IDLE = 1'h1;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	// ----------------------------------------------------------------
	// word indices in the memory
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_SIGNATURE = 8'h00;
	localparam logic [IDX_W-1:0] IDX_FIRST = 8'h01;
	localparam logic [IDX_W-1:0] IDX_STATION_LAST = 8'h03;
	localparam logic [IDX_W-1:0] IDX_GENERAL_CONTROL = 8'h04;
	localparam logic [IDX_W-1:0] IDX_CONTROL_LAST = 8'h10;
	localparam logic [IDX_W-1:0] IDX_OWN_IP_HIGH = 8'h11;
	localparam logic [IDX_W-1:0] IDX_IP_LAST = 8'h1E;
	localparam logic [IDX_W-1:0] IDX_LOCAL_PORT = 8'h1F;
	localparam logic [IDX_W-1:0] IDX_LAST = 8'h22;
	localparam logic [IDX_W-1:0] IDX_RSVD_FIRST = 8'h23;
	localparam logic [IDX_W-1:0] IDX_RSVD_LAST = 8'h27;
	// ----------------------------------------------------------------
	// loaded word carrier
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		GRP_STATION = 2'h0,
		GRP_CONTROL = 2'h1,
		GRP_IP = 2'h2,
		GRP_PORT = 2'h3
	} secl_group_e;
	typedef struct packed {
		logic [IDX_W-1:0] index;
		secl_group_e group;
		logic high_half;
		logic [WORD_W-1:0] data;
	} secl_word_s;
endpackage : secl_pkg

/* verilog/secl_fifo.sv */
`timescale 1ns/1ns
module secl_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PTR_W-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [PTR_W:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready_o = cnt_r != (PTR_W+1)'(DEPTH);
	assign out_valid_o = cnt_r != '0;
	assign out_data_o = mem_r[rd_r];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wr_nxt = (wr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_r + 1'h1;
		end
		if (pop) begin
			rd_nxt = (rd_r == PTR_W'(DEPTH - 1)) ? '0 : rd_r + 1'h1;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'h1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
		if (push) begin
			mem_r[wr_r] <= in_data_i;
		end
	end
endmodule : secl_fifo

/* verilog/secl_shifter.sv */
`timescale 1ns/1ns
module secl_shifter #(
	parameter int DIV_W = 8,
	parameter int POLL_MAX = 65535
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic start_i,
	input wire logic [secl_pkg::FRAME_W-1:0] frame_i,
	input wire logic [secl_pkg::LEN_W-1:0] len_i,
	input wire logic rx_en_i,
	input wire logic poll_en_i,
	input wire logic [DIV_W-1:0] div_i,
	input wire logic sdi_i,
	output logic done_o,
	output logic fail_o,
	output logic [secl_pkg::WORD_W-1:0] rx_o,
	output logic cs_o,
	output logic sk_o,
	output logic sdo_o
);
	typedef enum logic [4:0] {
		SH_IDLE = 5'h01, SH_TX = 5'h02, SH_RX = 5'h04, SH_GAP = 5'h08, SH_POLL = 5'h10
	} secl_shst_e;
	secl_shst_e st_r, st_nxt;
	logic [DIV_W-1:0] div_r, div_nxt;
	logic [secl_pkg::FRAME_W-1:0] sh_r, sh_nxt;
	logic [secl_pkg::LEN_W-1:0] cnt_r, cnt_nxt;
	logic [15:0] poll_r, poll_nxt;
	logic sk_nxt, cs_nxt, sdo_nxt, done_nxt, fail_nxt, rxen_r, rxen_nxt, pen_r, pen_nxt;
	logic [secl_pkg::WORD_W-1:0] rx_nxt;
	logic tick, fall;

	// half period of the serial clock is div_i+1 system clocks
	assign tick = (st_r != SH_IDLE) && (div_r == div_i);
	assign fall = tick && sk_o;

	always_comb begin
		st_nxt = st_r;
		div_nxt = tick ? '0 : div_r + 1'h1;
		sk_nxt = tick ? !sk_o : sk_o;
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		poll_nxt = poll_r;
		cs_nxt = cs_o;
		sdo_nxt = sdo_o;
		rx_nxt = rx_o;
		done_nxt = 1'h0;
		fail_nxt = fail_o;
		rxen_nxt = rxen_r;
		pen_nxt = pen_r;
		case (st_r)
			SH_IDLE: begin
				div_nxt = '0;
				sk_nxt = 1'h0;
				if (start_i) begin
					sh_nxt = frame_i;
					cnt_nxt = len_i;
					rxen_nxt = rx_en_i;
					pen_nxt = poll_en_i;
					fail_nxt = 1'h0;
					st_nxt = SH_TX;
				end
			end
			SH_TX: if (fall) begin
				if (cnt_r != '0) begin
					cs_nxt = 1'h1;
					sdo_nxt = sh_r[secl_pkg::FRAME_W-1];
					sh_nxt = {sh_r[secl_pkg::FRAME_W-2:0], 1'h0};
					cnt_nxt = cnt_r - 1'h1;
				end else if (rxen_r) begin
					// dummy bit ahead of the data word
					sdo_nxt = 1'h0;
					rx_nxt = {rx_o[secl_pkg::WORD_W-2:0], sdi_i};
					cnt_nxt = secl_pkg::RX_BITS;
					st_nxt = SH_RX;
				end else begin
					sdo_nxt = 1'h0;
					cs_nxt = 1'h0;
					st_nxt = pen_r ? SH_GAP : SH_IDLE;
					done_nxt = !pen_r;
				end
			end
			SH_RX: if (fall) begin
				rx_nxt = {rx_o[secl_pkg::WORD_W-2:0], sdi_i};
				cnt_nxt = cnt_r - 1'h1;
				if (cnt_r == 6'h01) begin
					cs_nxt = 1'h0;
					done_nxt = 1'h1;
					st_nxt = SH_IDLE;
				end
			end
			SH_GAP: if (fall) begin
				cs_nxt = 1'h1;
				poll_nxt = '0;
				st_nxt = SH_POLL;
			end
			SH_POLL: if (fall) begin
				if (sdi_i || poll_r == 16'(POLL_MAX)) begin
					cs_nxt = 1'h0;
					fail_nxt = !sdi_i;
					done_nxt = 1'h1;
					st_nxt = SH_IDLE;
				end else begin
					poll_nxt = poll_r + 1'h1;
				end
			end
			default: st_nxt = SH_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_r <= SH_IDLE;
			div_r <= '0;
			sh_r <= '0;
			cnt_r <= '0;
			poll_r <= '0;
			sk_o <= 1'h0;
			cs_o <= 1'h0;
			sdo_o <= 1'h0;
			rx_o <= secl_pkg::WORD_RST;
			done_o <= 1'h0;
			fail_o <= 1'h0;
			rxen_r <= 1'h0;
			pen_r <= 1'h0;
		end else begin
			st_r <= st_nxt;
			div_r <= div_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			poll_r <= poll_nxt;
			sk_o <= sk_nxt;
			cs_o <= cs_nxt;
			sdo_o <= sdo_nxt;
			rx_o <= rx_nxt;
			done_o <= done_nxt;
			fail_o <= fail_nxt;
			rxen_r <= rxen_nxt;
			pen_r <= pen_nxt;
		end
	end

	a_cs_on_fall: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$changed(cs_o) |-> $past(fall)) else $error("chip select moved off a falling edge");
	a_sdo_on_fall: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$changed(sdo_o) |-> $past(fall)) else $error("serial out moved off a falling edge");
	a_poll_ends_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_r == SH_POLL && fall && sdi_i) |=> (!cs_o && done_o && st_r == SH_IDLE))
		else $error("busy poll did not finish on ready");
	a_rx_sixteen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_r == SH_TX && fall && cnt_r == '0 && rxen_r) |=> (st_r == SH_RX && cnt_r == 6'h10))
		else $error("read phase did not start with sixteen bits");
endmodule : secl_shifter

/* verilog/secl_config_loader.sv */
`timescale 1ns/1ns
// Behaviour
// - every memory location moves as one whole 16-bit word.
// - word 00h must match the signature, else no further memory access.
// - with valid signature, words 01h to 22h are loaded after reset.
// - words 01h to 03h load the three station address words in order.
// - words 04h to 10h load the thirteen control registers in order.
// - words 11h to 1Eh load IP addresses, high word then low word.
// - words 1Fh to 22h load local port, destination port, serial mode, timeout.
// - words 23h to 27h are reserved and never loaded.
// - read opcode is 10, write opcode is 01.
// - write-enable pattern is 0011, write-disable pattern is 0000.
// - an undriven serial input reads high through the pull-up.
// - chip select and serial out change, input sampled, on serial clock fall.
// - after command and address of a read, the data word is shifted in.
// - every write is preceded by a separate write-enable frame.
// - after write data, drop select once, raise it, poll until input is 1; the code gives up after POLL_MAX+1 low polls and sets write_error_o.
// - after a write completes, write-disable is issued.
// - each reset starts an automatic read from word 0.
// - absent memory or wrong signature leaves all registers at reset values.
// - serial clock is divided from the system clock by a divider field.
module secl_config_loader #(
	parameter int ADDR_W = 6,
	parameter int DIV_W = 8,
	parameter int FIFO_DEPTH = 16,
	parameter int POLL_MAX = 65535,
	// arbitrary value
	parameter logic [15:0] SIGNATURE = 16'h5AA5
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [DIV_W-1:0] serial_clock_divider_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [secl_pkg::IDX_W-1:0] cmd_index_i,
	input wire logic [secl_pkg::WORD_W-1:0] cmd_data_i,
	output logic cmd_ready_o,
	output logic cfg_valid_o,
	output secl_pkg::secl_word_s cfg_word_o,
	input wire logic cfg_ready_i,
	output logic load_done_o,
	output logic mem_invalid_o,
	output logic write_error_o,
	output logic eeprom_chip_select_o,
	output logic eeprom_serial_clock_o,
	output logic eeprom_serial_out_o,
	input wire logic eeprom_serial_in_i
);
	// ----------------------------------------------------------------
	// types and helpers
	// ----------------------------------------------------------------
	typedef enum logic [9:0] {
		ST_BOOT = 10'h001,
		ST_SIG = 10'h002,
		ST_LOAD = 10'h004,
		ST_NEXT = 10'h008,
		ST_IDLE = 10'h010,
		ST_READ = 10'h020,
		ST_WEN = 10'h040,
		ST_WR = 10'h080,
		ST_WDS = 10'h100,
		ST_HALT = 10'h200
	} secl_state_e;

	localparam logic [secl_pkg::LEN_W-1:0] HEAD_LEN = secl_pkg::HEAD_BITS
		+ secl_pkg::LEN_W'(ADDR_W);

	function automatic logic [secl_pkg::FRAME_W-1:0] make_frame(
		input logic [1:0] op,
		input logic [secl_pkg::IDX_W-1:0] addr,
		input logic [secl_pkg::WORD_W-1:0] data
	);
		logic [secl_pkg::FRAME_W-1:0] f;
		f = '0;
		f[31] = secl_pkg::START_BIT;
		f[30:29] = op;
		for (int i = 0; i < ADDR_W; i++) begin
			f[28-i] = addr[ADDR_W-1-i];
		end
		for (int i = 0; i < secl_pkg::WORD_W; i++) begin
			f[28-ADDR_W-i] = data[secl_pkg::WORD_W-1-i];
		end
		return f;
	endfunction : make_frame

	// extension commands carry their code in the top two address bits
	function automatic logic [secl_pkg::IDX_W-1:0] ext_addr(input logic [1:0] code);
		logic [secl_pkg::IDX_W-1:0] a;
		a = '0;
		a[ADDR_W-1 -: 2] = code;
		return a;
	endfunction : ext_addr

	function automatic secl_pkg::secl_word_s make_word(
		input logic [secl_pkg::IDX_W-1:0] idx,
		input logic [secl_pkg::WORD_W-1:0] data
	);
		secl_pkg::secl_word_s w;
		w.index = idx;
		w.data = data;
		w.high_half = 1'h0;
		if (idx <= secl_pkg::IDX_STATION_LAST) begin
			w.group = secl_pkg::GRP_STATION;
		end else if (idx <= secl_pkg::IDX_CONTROL_LAST) begin
			w.group = secl_pkg::GRP_CONTROL;
		end else if (idx <= secl_pkg::IDX_IP_LAST) begin
			w.group = secl_pkg::GRP_IP;
			w.high_half = idx[0];
		end else begin
			w.group = secl_pkg::GRP_PORT;
		end
		return w;
	endfunction : make_word

	// ----------------------------------------------------------------
	// serial input synchroniser
	// ----------------------------------------------------------------
	logic di_meta_r, di_sync_r;

	// reset level is the pulled-up idle level
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			di_meta_r <= secl_pkg::SDI_IDLE;
			di_sync_r <= secl_pkg::SDI_IDLE;
		end else begin
			di_meta_r <= eeprom_serial_in_i;
			di_sync_r <= di_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// frame engine
	// ----------------------------------------------------------------
	logic start_r, start_nxt, rx_en_r, rx_en_nxt, poll_en_r, poll_en_nxt;
	logic [secl_pkg::FRAME_W-1:0] frame_r, frame_nxt;
	logic [secl_pkg::LEN_W-1:0] len_r, len_nxt;
	logic sh_done, sh_fail;
	logic [secl_pkg::WORD_W-1:0] sh_rx;

	secl_shifter #(
		.DIV_W(DIV_W),
		.POLL_MAX(POLL_MAX)
	) u_shifter (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(start_r),
		.frame_i(frame_r),
		.len_i(len_r),
		.rx_en_i(rx_en_r),
		.poll_en_i(poll_en_r),
		.div_i(serial_clock_divider_i),
		.sdi_i(di_sync_r),
		.done_o(sh_done),
		.fail_o(sh_fail),
		.rx_o(sh_rx),
		.cs_o(eeprom_chip_select_o),
		.sk_o(eeprom_serial_clock_o),
		.sdo_o(eeprom_serial_out_o)
	);

	// ----------------------------------------------------------------
	// word buffer
	// ----------------------------------------------------------------
	logic push_r, push_nxt, fifo_in_ready, fifo_out_valid;
	secl_pkg::secl_word_s word_r, word_nxt, fifo_out;
	logic cfg_valid_nxt;
	secl_pkg::secl_word_s cfg_word_nxt;

	secl_fifo #(
		.WIDTH($bits(secl_pkg::secl_word_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(push_r),
		.in_data_i(word_r),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(fifo_out_valid),
		.out_data_o(fifo_out),
		.out_ready_i(!cfg_valid_o || cfg_ready_i)
	);

	always_comb begin
		cfg_valid_nxt = cfg_valid_o;
		cfg_word_nxt = cfg_word_o;
		if (!cfg_valid_o || cfg_ready_i) begin
			cfg_valid_nxt = fifo_out_valid;
			cfg_word_nxt = fifo_out_valid ? fifo_out : cfg_word_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg_valid_o <= 1'h0;
			cfg_word_o <= '0;
		end else begin
			cfg_valid_o <= cfg_valid_nxt;
			cfg_word_o <= cfg_word_nxt;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	secl_state_e st_r, st_nxt;
	logic [secl_pkg::IDX_W-1:0] idx_r, idx_nxt, go_addr;
	logic [secl_pkg::WORD_W-1:0] wdata_r, wdata_nxt, go_data;
	logic [1:0] go_op;
	logic go, go_rx, go_poll, cmd_ready_nxt, load_done_nxt, invalid_nxt, werr_nxt;

	always_comb begin
		st_nxt = st_r;
		idx_nxt = idx_r;
		wdata_nxt = wdata_r;
		push_nxt = push_r && !fifo_in_ready;
		word_nxt = word_r;
		load_done_nxt = load_done_o;
		invalid_nxt = mem_invalid_o;
		werr_nxt = write_error_o;
		go = 1'h0;
		go_op = secl_pkg::OP_READ;
		go_addr = idx_r;
		go_data = '0;
		go_rx = 1'h1;
		go_poll = 1'h0;
		case (st_r)
			ST_BOOT: begin
				go = 1'h1;
				go_addr = secl_pkg::IDX_SIGNATURE;
				st_nxt = ST_SIG;
			end
			ST_SIG: if (sh_done) begin
				if (sh_rx == SIGNATURE) begin
					go = 1'h1;
					go_addr = secl_pkg::IDX_FIRST;
					idx_nxt = secl_pkg::IDX_FIRST;
					st_nxt = ST_LOAD;
				end else begin
					invalid_nxt = 1'h1;
					st_nxt = ST_HALT;
				end
			end
			ST_LOAD: if (sh_done) begin
				push_nxt = 1'h1;
				word_nxt = make_word(idx_r, sh_rx);
				if (idx_r == secl_pkg::IDX_LAST) begin
					load_done_nxt = 1'h1;
					st_nxt = ST_IDLE;
				end else begin
					idx_nxt = idx_r + 1'h1;
					st_nxt = ST_NEXT;
				end
			end
			ST_NEXT: if (!push_r) begin
				go = 1'h1;
				st_nxt = ST_LOAD;
			end
			ST_IDLE: if (cmd_valid_i && cmd_ready_o) begin
				idx_nxt = cmd_index_i;
				wdata_nxt = cmd_data_i;
				go = 1'h1;
				go_addr = cmd_index_i;
				st_nxt = ST_READ;
				if (cmd_write_i) begin
					go_op = secl_pkg::OP_EXT;
					go_addr = ext_addr(secl_pkg::EXT_WEN);
					go_rx = 1'h0;
					st_nxt = ST_WEN;
				end
			end
			ST_READ: if (sh_done) begin
				push_nxt = 1'h1;
				word_nxt = make_word(idx_r, sh_rx);
				st_nxt = ST_IDLE;
			end
			ST_WEN: if (sh_done) begin
				go = 1'h1;
				go_op = secl_pkg::OP_WRITE;
				go_data = wdata_r;
				go_rx = 1'h0;
				go_poll = 1'h1;
				st_nxt = ST_WR;
			end
			ST_WR: if (sh_done) begin
				werr_nxt = sh_fail;
				go = 1'h1;
				go_op = secl_pkg::OP_EXT;
				go_addr = ext_addr(secl_pkg::EXT_WDS);
				go_rx = 1'h0;
				st_nxt = ST_WDS;
			end
			ST_WDS: if (sh_done) begin
				st_nxt = ST_IDLE;
			end
			ST_HALT: st_nxt = ST_HALT;
			default: st_nxt = ST_BOOT;
		endcase
		start_nxt = go;
		frame_nxt = go ? make_frame(go_op, go_addr, go_data) : frame_r;
		len_nxt = len_r;
		if (go) begin
			len_nxt = (go_op == secl_pkg::OP_WRITE) ? HEAD_LEN + secl_pkg::DATA_BITS : HEAD_LEN;
		end
		rx_en_nxt = go ? go_rx : rx_en_r;
		poll_en_nxt = go ? go_poll : poll_en_r;
		cmd_ready_nxt = (st_nxt == ST_IDLE) && !push_nxt && !go;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_r <= ST_BOOT;
			idx_r <= secl_pkg::IDX_SIGNATURE;
			wdata_r <= secl_pkg::WORD_RST;
			push_r <= 1'h0;
			word_r <= '0;
			start_r <= 1'h0;
			frame_r <= '0;
			len_r <= '0;
			rx_en_r <= 1'h0;
			poll_en_r <= 1'h0;
			cmd_ready_o <= 1'h0;
			load_done_o <= 1'h0;
			mem_invalid_o <= 1'h0;
			write_error_o <= 1'h0;
		end else begin
			st_r <= st_nxt;
			idx_r <= idx_nxt;
			wdata_r <= wdata_nxt;
			push_r <= push_nxt;
			word_r <= word_nxt;
			start_r <= start_nxt;
			frame_r <= frame_nxt;
			len_r <= len_nxt;
			rx_en_r <= rx_en_nxt;
			poll_en_r <= poll_en_nxt;
			cmd_ready_o <= cmd_ready_nxt;
			load_done_o <= load_done_nxt;
			mem_invalid_o <= invalid_nxt;
			write_error_o <= werr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_sig_read_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(start_r && st_r == ST_SIG) |-> (frame_r[31:29] == 3'h6 && frame_r[28 -: ADDR_W] == '0))
		else $error("first frame is not a read of word zero");
	a_read_opcode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(start_r && (st_r == ST_LOAD || st_r == ST_READ)) |-> (frame_r[31:29] == 3'h6
		&& rx_en_r && len_r == HEAD_LEN)) else $error("read frame badly formed");
	a_ext_pattern: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(start_r && (st_r == ST_WEN || st_r == ST_WDS)) |-> (frame_r[30:27]
		== ((st_r == ST_WEN) ? 4'h3 : 4'h0))) else $error("enable or disable pattern wrong");
	a_wen_before_wr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_r == ST_WR && $past(st_r) != ST_WR) |-> ($past(st_r) == ST_WEN && start_r
		&& frame_r[30:29] == 2'h1 && poll_en_r)) else $error("write without enable frame");
	a_wds_after_wr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		($past(st_r) == ST_WR && st_r != ST_WR) |-> (st_r == ST_WDS && start_r))
		else $error("write not followed by disable");
	a_load_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_r == ST_LOAD && sh_done) |=> (push_r && word_r.index >= 8'h01
		&& word_r.index <= 8'h22)) else $error("loaded word outside 01h to 22h");
	a_halt_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		mem_invalid_o |-> (!eeprom_chip_select_o && !start_r && !push_r && !load_done_o))
		else $error("invalid memory still accessed");
endmodule : secl_config_loader

/* test/secl_eeprom_model.sv */
`timescale 1ns/1ns
module secl_eeprom_model #(
	parameter int ADDR_W = 6
) (
	input wire logic clk_i,
	input wire logic present_i,
	input wire logic [15:0] busy_clks_i,
	input wire logic cs_i,
	input wire logic sk_i,
	input wire logic di_i,
	output logic do_o
);
	logic [15:0] mem [0:(1<<ADDR_W)-1];
	logic [31:0] sh = '0;
	logic [15:0] rd_sh = '0;
	logic [1:0] op = '0;
	logic [ADDR_W-1:0] addr = '0;
	logic wen = 1'b0;
	logic rd_mode = 1'b0;
	logic poll = 1'b0;
	logic arm = 1'b0;
	logic pend = 1'b0;
	logic dout = 1'b1;
	int nbits = 0;
	int busy_left = 0;
	int n_bad = 0;
	// ----
	// pin: released or absent line floats high
	// ----
	assign do_o = (present_i && cs_i && (rd_mode || poll)) ? (poll ? (busy_left == 0) : dout) : 1'b1;
	always @(posedge clk_i) begin
		if (busy_left > 0) busy_left = busy_left - 1;
	end
	always @(posedge cs_i) begin
		nbits = 0;
		poll = arm;
		arm = 1'b0;
	end
	always @(negedge cs_i) begin
		rd_mode = 1'b0;
		poll = 1'b0;
		if (pend && !wen) n_bad++;
		if (pend && wen) begin
			mem[addr] = sh[15:0];
			busy_left = busy_clks_i;
			arm = 1'b1;
		end
		pend = 1'b0;
	end
	// ----
	// command decode on rising serial clock
	// ----
	always @(posedge sk_i) begin
		if (cs_i && !poll && rd_mode) begin
			dout = rd_sh[15];
			rd_sh = rd_sh << 1;
		end else if (cs_i && !poll) begin
			sh = {sh[30:0], di_i};
			nbits++;
			if (nbits == 3 + ADDR_W) begin
				if (!sh[ADDR_W+2]) n_bad++;
				op = sh[ADDR_W+1:ADDR_W];
				addr = sh[ADDR_W-1:0];
				if (op == 2'h2) begin
					rd_mode = 1'b1;
					dout = 1'b0;
					rd_sh = mem[addr];
				end else if (op == 2'h0 && addr[ADDR_W-1 -: 2] == 2'h3) wen = 1'b1;
				else if (op == 2'h0 && addr[ADDR_W-1 -: 2] == 2'h0) wen = 1'b0;
				else if (op != 2'h1) n_bad++;
			end
			if (nbits == 19 + ADDR_W && op == 2'h1) pend = 1'b1;
		end
	end
	// lines may move only while the serial clock is low
	always @(cs_i or di_i) begin
		#1;
		if (sk_i) n_bad++;
	end
endmodule : secl_eeprom_model

/* test/tb.sv */
`timescale 1ns/1ns
module tb;
	localparam logic [15:0] SIG = 16'h5AA5;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] div = 8'h02;
	logic cmd_valid_i = 1'b0;
	logic cmd_write_i = 1'b0;
	logic [7:0] cmd_index_i = 8'h00;
	logic [15:0] cmd_data_i = 16'h0000;
	logic cfg_ready_i = 1'b0;
	logic present = 1'b1;
	logic [15:0] busy_clks = 16'h001E;
	logic cmd_ready_o, cfg_valid_o, load_done_o, mem_invalid_o, write_error_o, cs, sk, sdo, sdi;
	logic sk_q = 1'b0;
	secl_pkg::secl_word_s cfg_word_o;
	secl_pkg::secl_word_s gotq[$];
	logic [15:0] img [0:63];
	int n_mismatch = 0;
	int n_checks = 0;
	int seed = 32'hA5832A59;
	int rdy_mode = 0;
	int run = 0;
	int n_div_bad = 0;
	logic [7:0] ix;
	logic [15:0] wd;
	secl_config_loader #(.POLL_MAX(20), .SIGNATURE(SIG)) dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .serial_clock_divider_i(div),
		.cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_index_i(cmd_index_i),
		.cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .cfg_valid_o(cfg_valid_o),
		.cfg_word_o(cfg_word_o), .cfg_ready_i(cfg_ready_i), .load_done_o(load_done_o),
		.mem_invalid_o(mem_invalid_o), .write_error_o(write_error_o),
		.eeprom_chip_select_o(cs), .eeprom_serial_clock_o(sk), .eeprom_serial_out_o(sdo),
		.eeprom_serial_in_i(sdi)
	);
	secl_eeprom_model #(.ADDR_W(6)) u_mem (.clk_i(clk_i), .present_i(present),
		.busy_clks_i(busy_clks), .cs_i(cs), .sk_i(sk), .di_i(sdo), .do_o(sdi));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// ----
	// consumer, stream capture, serial clock period watch
	// ----
	always @(posedge clk_i) begin
		if (!sys_rst_i && cfg_valid_o && cfg_ready_i) gotq.push_back(cfg_word_o);
		cfg_ready_i <= (rdy_mode == 2) || (rdy_mode == 1 && $random(seed) % 2 == 0);
		sk_q <= sk;
		run <= (sk !== sk_q) ? 1 : run + 1;
		if (sk !== sk_q && cs === 1'b1 && run < 40 && run != div + 1) n_div_bad++;
	end
	task automatic chk_word(input secl_pkg::secl_word_s exp, input secl_pkg::secl_word_s got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t exp %h got %h", $time, exp, got);
		end
	endtask : chk_word
	task automatic chk_flag(input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t exp %h got %h", $time, exp, got);
		end
	endtask : chk_flag
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test
	function automatic secl_pkg::secl_word_s exp_word(input logic [7:0] i);
		secl_pkg::secl_word_s w;
		w.index = i;
		w.data = img[i[5:0]];
		w.group = (i <= 8'h03) ? secl_pkg::GRP_STATION : (i <= 8'h10) ? secl_pkg::GRP_CONTROL :
			(i <= 8'h1E) ? secl_pkg::GRP_IP : secl_pkg::GRP_PORT;
		w.high_half = (i >= 8'h11) && (i <= 8'h1E) && i[0];
		return w;
	endfunction : exp_word
	task automatic do_reset(input logic [15:0] sig, input logic pres);
		for (int i = 0; i < 64; i++) begin
			img[i] = 16'($random(seed));
			u_mem.mem[i] = img[i];
		end
		img[0] = sig;
		u_mem.mem[0] = sig;
		present <= pres;
		sys_rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		gotq.delete();
	endtask : do_reset
	task automatic wait_ready();
		int k;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (cmd_ready_o !== 1'b1 && k < 9000);
	endtask : wait_ready
	task automatic do_cmd(input logic wr, input logic [7:0] idx, input logic [15:0] d);
		cmd_write_i <= wr;
		cmd_index_i <= idx;
		cmd_data_i <= d;
		cmd_valid_i <= 1'b1;
		wait_ready();
		cmd_valid_i <= 1'b0;
		wait_ready();
	endtask : do_cmd
	task automatic chk_read(input logic [7:0] idx);
		for (int i = 0; i < 200 && gotq.size() == 0; i++) @(posedge clk_i);
		chk_word(exp_word(idx), gotq[0]);
		gotq.delete();
	endtask : chk_read
	task automatic chk_load();
		for (int i = 0; i < 20000 && gotq.size() < 34; i++) @(posedge clk_i);
		repeat (1000) @(posedge clk_i);
		chk_flag(1'b1, load_done_o);
		chk_flag(1'b1, gotq.size() == 34);
		for (int i = 0; i < 34; i++) chk_word(exp_word(8'(i + 1)), gotq[i]);
		chk_flag(1'b0, mem_invalid_o);
		chk_flag(1'b1, cmd_ready_o);
		gotq.delete();
	endtask : chk_load
	task automatic chk_invalid();
		int hi;
		hi = 0;
		for (int i = 0; i < 8000 && mem_invalid_o !== 1'b1; i++) @(posedge clk_i);
		for (int i = 0; i < 2000; i++) begin
			@(posedge clk_i);
			if (cs !== 1'b0) hi++;
		end
		chk_flag(1'b1, mem_invalid_o);
		chk_flag(1'b1, hi == 0);
		chk_flag(1'b0, cmd_ready_o | load_done_o | cfg_valid_o | (gotq.size() != 0));
	endtask : chk_invalid
	// ----
	// main sequence
	// ----
	initial begin
		do_reset(SIG, 1'b1);
		// consumer stalled: the buffer must fill and hold the load back
		repeat (4000) @(posedge clk_i);
		chk_flag(1'b1, cfg_valid_o);
		chk_flag(1'b0, load_done_o);
		rdy_mode = 1;
		chk_load();
		for (int k = 0; k < 3; k++) begin
			ix = 8'(1 + {$random(seed)} % 34);
			do_cmd(1'b0, ix, 16'h0000);
			chk_read(ix);
		end
		wd = 16'($random(seed));
		do_cmd(1'b1, 8'h20, wd);
		img[32] = wd;
		chk_flag(1'b0, write_error_o);
		chk_flag(1'b0, u_mem.wen);
		chk_flag(1'b1, u_mem.n_bad == 0);
		do_cmd(1'b0, 8'h20, 16'h0000);
		chk_read(8'h20);
		busy_clks <= 16'h07D0;
		do_cmd(1'b1, 8'h21, wd);
		chk_flag(1'b1, write_error_o);
		repeat (2100) @(posedge clk_i);
		div <= 8'h03;
		do_reset(~SIG, 1'b1);
		chk_invalid();
		do_reset(SIG, 1'b0);
		chk_invalid();
		do_reset(SIG, 1'b1);
		chk_load();
		chk_flag(1'b1, n_div_bad == 0);
		finish_test();
	end
	initial begin
		repeat (90000) @(posedge clk_i);
		n_mismatch++;
		finish_test();
	end
endmodule : tb
